/* File: include/rcs_cfg.svh */
`ifndef RCS_CFG_SVH
`define RCS_CFG_SVH
// register offsets (own choice, word index on the plain port)
`define RCS_ADDR_CAUSE 4'h0
`define RCS_ADDR_STATUS 4'h1
`define RCS_ADDR_POWER_UP_TIMER 4'h2
// cause register bit positions
`define RCS_BIT_POR 0
`define RCS_BIT_BOR 1
`define RCS_BIT_IDLE 2
`define RCS_BIT_SLEEP 3
`define RCS_BIT_WATCHDOG_TIMEOUT_FLAG 4
`define RCS_BIT_WDEN 5
`define RCS_BIT_SWR 6
`define RCS_BIT_EXTERNAL_PIN_RESET_FLAG 7
`define RCS_BIT_VREG 8
`define RCS_BIT_CM 9
`define RCS_BIT_ILL 14
`define RCS_BIT_TRAP 15
// implemented bits of the cause register
`define RCS_CAUSE_MASK 16'hc3ff
// value after power-on: power-on and brown-out flags set
`define RCS_CAUSE_POR_VAL 16'h0003
// timing at 20 MHz (50 ns)
`define RCS_CLK_NS 50
`define RCS_TPOR_NS 30000
`define RCS_TBOR_NS 100000
`define RCS_TLOCK_NS 1500000
`define RCS_TFSCM_NS 900000
`define RCS_TPWRT_MS 128
`define RCS_OST_PERIODS 1024
// first fetch address once the clock is ready
`define RCS_RESET_VECTOR 24'h000000
// longest time rounds down
`define RCS_TPOR_CYC (`RCS_TPOR_NS / `RCS_CLK_NS)
`define RCS_TBOR_CYC (`RCS_TBOR_NS / `RCS_CLK_NS)
`define RCS_TFSCM_CYC (`RCS_TFSCM_NS / `RCS_CLK_NS)
`define RCS_TLOCK_CYC (`RCS_TLOCK_NS / `RCS_CLK_NS)
`define RCS_TPWRT_CYC (`RCS_TPWRT_MS * 1000000 / `RCS_CLK_NS)
`endif

/* File: include/rcs_pkg.sv */
package rcs_pkg;
    // release sequencer states
    typedef enum logic [2:0] {
        RCS_HOLD = 3'b000,
        RCS_EXT = 3'b001,
        RCS_POWER_UP_TIMER = 3'b010,
        RCS_OST = 3'b011,
        RCS_LOCK = 3'b100,
        RCS_RUN = 3'b101
    } rcs_state_t;
    // clock modes
    typedef enum logic [2:0] {
        RCS_MODE_FRC = 3'b000,
        RCS_MODE_FRCPLL = 3'b001,
        RCS_MODE_XT = 3'b010,
        RCS_MODE_HS = 3'b011,
        RCS_MODE_EC = 3'b100,
        RCS_MODE_XTPLL = 3'b101,
        RCS_MODE_HSPLL = 3'b110,
        RCS_MODE_ECPLL = 3'b111
    } rcs_mode_t;
endpackage : rcs_pkg

/* File: logic/rcs_delay_timer.sv */
`include "rcs_cfg.svh"
// loadable down counter; done is high when it has reached zero
module rcs_delay_timer
    import rcs_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic load,
    input wire logic [31:0] value,
    output logic done
);
    logic [31:0] cnt_r;
    // count down toward zero, reload on request
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 32'h0;
        end else if (load) begin
            cnt_r <= value;
        end else if (cnt_r != 32'h0) begin
            cnt_r <= cnt_r - 32'h1;
        end
    end
    // done looks at the count only: the caller's load is built from it
    assign done = (cnt_r == 32'h0);
endmodule : rcs_delay_timer

/* File: logic/rcs_sequencer.sv */
// Function
// - reset out while any source active
// - each reset sets its cause flag
// - power-on clears flags except power-on flag; code also sets the brown-out flag and keeps bit 8
// - software writes flags, never causes reset
// - illegal condition sets bit 14
// - configuration mismatch sets bit 9
// - reset instruction sets bit 6
// - brown-out sets bit 1
// - power-up sets bit 0
// - bit 8 keeps regulator on in sleep
// - bit 5 or fuse enables watchdog
// - power-on/brown-out cold, initial clock select
// - other resets warm, keep current clock
// - power-on extension up to 30 us
// - brown-out extension up to 100 us
// - power-up timer then release, oscillator starts
// - crystal modes wait 1024 oscillator periods
// - pll modes wait 1.5 ms lock
// - fetch starts at address zero when ready
// - clock-fail monitor starts 900 us after ready
// - reset instruction resets one cycle only
// - master-clear low resets, sets external flag
//
// The implementer's own choices: the register addresses and the strobed register port.
`include "rcs_cfg.svh"
module rcs_sequencer
    import rcs_pkg::*;
#(
    parameter int unsigned TPWRT_CYC = `RCS_TPWRT_CYC,
    parameter int unsigned TLOCK_CYC = `RCS_TLOCK_CYC,
    parameter int unsigned TFSCM_CYC = `RCS_TFSCM_CYC
) (
    input wire logic CLOCK,
    input wire logic RESET_N,
    input wire logic POWER_ON_DET,
    input wire logic BROWN_OUT_DET,
    input wire logic MASTER_CLEAR_PIN_N,
    input wire logic SOFT_RESET_INSN,
    input wire logic WATCHDOG_TIMEOUT,
    input wire logic CONFIG_MISMATCH,
    input wire logic TRAP_CONFLICT,
    input wire logic ILLEGAL_CONDITION,
    input wire logic SLEEP_ENTERED,
    input wire logic IDLE_ENTERED,
    input wire logic WATCHDOG_FUSE_ENABLE,
    input wire logic CLOCK_FAIL_ENABLE,
    input wire logic [2:0] INITIAL_CLOCK_SELECT,
    input wire logic [2:0] POWER_UP_TIMER_SELECT,
    input wire logic OSC_TICK,
    input wire logic [3:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic WRITE,
    input wire logic READ,
    output logic [15:0] RDATA,
    output logic SYSTEM_RESET_OUT,
    output logic COLD_RESET,
    output logic [2:0] CURRENT_CLOCK_SELECT,
    output logic CLOCK_READY,
    output logic [23:0] FETCH_ADDRESS,
    output logic FETCH_START,
    output logic CLOCK_FAIL_MONITOR_ON,
    output logic WATCHDOG_ENABLE,
    output logic REGULATOR_SLEEP_ACTIVE
);
    logic [15:0] reset_cause_control_r;
    logic [15:0] cause_nxt;
    rcs_state_t state_r;
    rcs_state_t state_nxt;
    logic [2:0] current_clock_select_r;
    logic [9:0] ost_cnt_r;
    logic cold_r;
    logic fsm_ready_r;
    logic clock_fail_monitor_wait_r;
    logic tmr_load;
    logic [31:0] tmr_value;
    logic tmr_done;
    logic ready_d_r;

    // pll and crystal mode decode
    function automatic logic mode_pll(input logic [2:0] m);
        mode_pll = (m == RCS_MODE_FRCPLL) || (m == RCS_MODE_XTPLL) || (m == RCS_MODE_HSPLL)
            || (m == RCS_MODE_ECPLL);
    endfunction : mode_pll
    function automatic logic mode_ost(input logic [2:0] m);
        mode_ost = (m == RCS_MODE_XT) || (m == RCS_MODE_HS) || (m == RCS_MODE_XTPLL)
            || (m == RCS_MODE_HSPLL);
    endfunction : mode_ost
    // power-up timer setting: 0 or 128 ms scaled by 2^(sel-7)
    function automatic logic [31:0] power_up_timer_cycles(input logic [2:0] sel);
        power_up_timer_cycles = (sel == 3'h0) ? 32'h0 : (32'(TPWRT_CYC) >> (3'h7 - sel));
    endfunction : power_up_timer_cycles

    logic cold_src;
    logic warm_src;
    logic any_src;
    assign cold_src = POWER_ON_DET || BROWN_OUT_DET;
    assign warm_src = !MASTER_CLEAR_PIN_N || SOFT_RESET_INSN || WATCHDOG_TIMEOUT
        || CONFIG_MISMATCH || TRAP_CONFLICT || ILLEGAL_CONDITION;
    assign any_src = cold_src || warm_src;

    // cause register: software write first, hardware sets win
    always_comb begin
        cause_nxt = reset_cause_control_r;
        if (WRITE && ADDR == `RCS_ADDR_CAUSE) begin
            cause_nxt = WDATA & `RCS_CAUSE_MASK;
        end
        if (POWER_ON_DET) begin
            cause_nxt = `RCS_CAUSE_POR_VAL | (cause_nxt & 16'(1 << `RCS_BIT_VREG));
        end else if (BROWN_OUT_DET) begin
            cause_nxt = cause_nxt | 16'(1 << `RCS_BIT_BOR); // pin flag survives brown-out
            cause_nxt = cause_nxt & ~16'(1 << `RCS_BIT_TRAP) & ~16'(1 << `RCS_BIT_ILL)
                & ~16'(1 << `RCS_BIT_CM) & ~16'(1 << `RCS_BIT_SWR) & ~16'(1 << `RCS_BIT_WATCHDOG_TIMEOUT_FLAG)
                & ~16'(1 << `RCS_BIT_SLEEP) & ~16'(1 << `RCS_BIT_IDLE);
        end
        if (!MASTER_CLEAR_PIN_N) cause_nxt[`RCS_BIT_EXTERNAL_PIN_RESET_FLAG] = 1'b1;
        if (SOFT_RESET_INSN) cause_nxt[`RCS_BIT_SWR] = 1'b1;
        if (WATCHDOG_TIMEOUT) cause_nxt[`RCS_BIT_WATCHDOG_TIMEOUT_FLAG] = 1'b1;
        if (CONFIG_MISMATCH) cause_nxt[`RCS_BIT_CM] = 1'b1;
        if (TRAP_CONFLICT) cause_nxt[`RCS_BIT_TRAP] = 1'b1;
        if (ILLEGAL_CONDITION) cause_nxt[`RCS_BIT_ILL] = 1'b1;
        if (SLEEP_ENTERED) cause_nxt[`RCS_BIT_SLEEP] = 1'b1;
        if (IDLE_ENTERED) cause_nxt[`RCS_BIT_IDLE] = 1'b1;
    end

    // flags only change here, so warm resets leave them standing
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            reset_cause_control_r <= `RCS_CAUSE_POR_VAL;
        end else begin
            reset_cause_control_r <= cause_nxt;
        end
    end

    assign REGULATOR_SLEEP_ACTIVE = reset_cause_control_r[`RCS_BIT_VREG];
    assign WATCHDOG_ENABLE = WATCHDOG_FUSE_ENABLE || reset_cause_control_r[`RCS_BIT_WDEN];

    // read port: data one cycle after the read strobe
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            RDATA <= 16'h0;
        end else if (READ) begin
            case (ADDR)
                `RCS_ADDR_CAUSE: RDATA <= reset_cause_control_r;
                `RCS_ADDR_STATUS: RDATA <= {8'h0, CLOCK_FAIL_MONITOR_ON, CLOCK_READY, cold_r,
                    current_clock_select_r, state_r[1:0]};
                default: RDATA <= 16'h0;
            endcase
        end else begin
            RDATA <= 16'h0;
        end
    end

    // cold flag remembers the kind of the last reset; a warm source cannot cut a cold sequence short
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            cold_r <= 1'b1;
        end else if (cold_src) begin
            cold_r <= 1'b1;
        end else if (warm_src && state_r == RCS_RUN) begin
            cold_r <= 1'b0;
        end
    end

    // clock source: reloaded from the initial select on cold reset only
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            current_clock_select_r <= 3'h0;
        end else if (cold_src || state_r == RCS_HOLD && cold_r) begin
            current_clock_select_r <= INITIAL_CLOCK_SELECT;
        end
    end

    // release sequencer
    always_comb begin
        state_nxt = state_r;
        tmr_load = 1'b0;
        tmr_value = 32'h0;
        if (any_src) begin
            state_nxt = RCS_HOLD;
        end else begin
            case (state_r)
                RCS_HOLD: begin
                    if (cold_r) begin
                        state_nxt = RCS_EXT;
                        tmr_load = 1'b1;
                        tmr_value = reset_cause_control_r[`RCS_BIT_POR] ?
                            32'(`RCS_TPOR_CYC) : 32'(`RCS_TBOR_CYC);
                    end else begin
                        state_nxt = RCS_RUN;
                    end
                end
                RCS_EXT: if (tmr_done) begin
                    state_nxt = RCS_POWER_UP_TIMER;
                    tmr_load = 1'b1;
                    tmr_value = power_up_timer_cycles(POWER_UP_TIMER_SELECT);
                end
                RCS_POWER_UP_TIMER: if (tmr_done) begin
                    state_nxt = mode_ost(current_clock_select_r) ? RCS_OST : RCS_LOCK;
                    tmr_load = 1'b1;
                    tmr_value = mode_pll(current_clock_select_r) ? 32'(TLOCK_CYC) : 32'h0;
                end
                RCS_OST: if (ost_cnt_r == 10'(`RCS_OST_PERIODS - 1) && OSC_TICK) begin
                    state_nxt = RCS_LOCK;
                    tmr_load = 1'b1;
                    tmr_value = mode_pll(current_clock_select_r) ? 32'(TLOCK_CYC) : 32'h0;
                end
                RCS_LOCK: if (tmr_done) state_nxt = RCS_RUN;
                RCS_RUN: state_nxt = RCS_RUN;
                default: state_nxt = RCS_HOLD;
            endcase
        end
    end

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            state_r <= RCS_HOLD;
        end else begin
            state_r <= state_nxt;
        end
    end

    // oscillator start-up timer counts oscillator ticks
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            ost_cnt_r <= 10'h0;
        end else if (state_r != RCS_OST) begin
            ost_cnt_r <= 10'h0;
        end else if (OSC_TICK) begin
            ost_cnt_r <= ost_cnt_r + 10'h1;
        end
    end

    rcs_delay_timer u_timer (
        .clk(CLOCK),
        .rst_n(RESET_N),
        .load(tmr_load),
        .value(tmr_value),
        .done(tmr_done)
    );

    // second counter for the clock-fail monitor delay
    logic [31:0] clock_fail_monitor_cnt_r;
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            clock_fail_monitor_cnt_r <= 32'h0;
            clock_fail_monitor_wait_r <= 1'b0;
        end else if (state_r != RCS_RUN || !CLOCK_FAIL_ENABLE) begin
            clock_fail_monitor_cnt_r <= 32'h0;
            clock_fail_monitor_wait_r <= 1'b0;
        end else if (clock_fail_monitor_cnt_r < 32'(TFSCM_CYC)) begin
            clock_fail_monitor_cnt_r <= clock_fail_monitor_cnt_r + 32'h1;
        end else begin
            clock_fail_monitor_wait_r <= 1'b1;
        end
    end

    // ready flags and fetch start pulse
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            fsm_ready_r <= 1'b0;
            ready_d_r <= 1'b0;
        end else begin
            fsm_ready_r <= state_nxt == RCS_RUN;
            ready_d_r <= fsm_ready_r;
        end
    end

    assign SYSTEM_RESET_OUT = state_r != RCS_RUN;
    assign CLOCK_READY = fsm_ready_r;
    assign FETCH_START = fsm_ready_r && !ready_d_r;
    assign FETCH_ADDRESS = `RCS_RESET_VECTOR;
    assign CLOCK_FAIL_MONITOR_ON = clock_fail_monitor_wait_r;
    assign COLD_RESET = cold_r;
    assign CURRENT_CLOCK_SELECT = current_clock_select_r;

    // reset output follows every source
    a_reset_follows_src: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        any_src |=> SYSTEM_RESET_OUT)
        else $error("reset out not asserted");

    // each source leaves its own flag set
    a_por_flag_set: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        POWER_ON_DET |=> reset_cause_control_r[`RCS_BIT_POR] && reset_cause_control_r[`RCS_BIT_BOR])
        else $error("power-on flag not set");
    a_bor_flag_set: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        BROWN_OUT_DET |=> reset_cause_control_r[`RCS_BIT_BOR])
        else $error("brown-out flag");
    a_swr_flag_set: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        SOFT_RESET_INSN |=> reset_cause_control_r[`RCS_BIT_SWR])
        else $error("software flag");
    a_cm_flag_set: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        CONFIG_MISMATCH |=> reset_cause_control_r[`RCS_BIT_CM])
        else $error("mismatch flag");
    a_ill_flag_set: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        ILLEGAL_CONDITION |=> reset_cause_control_r[`RCS_BIT_ILL])
        else $error("illegal flag");
    a_external_pin_reset_flag_flag_set: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        !MASTER_CLEAR_PIN_N |=> reset_cause_control_r[`RCS_BIT_EXTERNAL_PIN_RESET_FLAG] && SYSTEM_RESET_OUT)
        else $error("pin reset flag");
    a_trap_flag_set: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        TRAP_CONFLICT |=> reset_cause_control_r[`RCS_BIT_TRAP])
        else $error("trap flag");
    a_watchdog_timeout_flag_flag_set: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        WATCHDOG_TIMEOUT |=> reset_cause_control_r[`RCS_BIT_WATCHDOG_TIMEOUT_FLAG])
        else $error("watchdog flag");

    // power-on wipes flags that no source sets again
    a_por_clears: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        POWER_ON_DET && !TRAP_CONFLICT |=> !reset_cause_control_r[`RCS_BIT_TRAP])
        else $error("power-on did not clear");

    // software access never resets and drives the control bits
    a_write_no_reset: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        WRITE && !any_src && !SYSTEM_RESET_OUT |=> !SYSTEM_RESET_OUT)
        else $error("write caused reset");
    a_vreg_follows_write: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        WRITE && ADDR == `RCS_ADDR_CAUSE && !POWER_ON_DET && !BROWN_OUT_DET
        |=> REGULATOR_SLEEP_ACTIVE == $past(WDATA[`RCS_BIT_VREG]))
        else $error("regulator bit not written");
    a_wdt_fuse: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        WATCHDOG_FUSE_ENABLE |-> WATCHDOG_ENABLE)
        else $error("fuse ignored");

    // clock source on cold and warm resets, flags kept across warm ones
    a_cold_loads_sel: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        cold_src |=> CURRENT_CLOCK_SELECT == $past(INITIAL_CLOCK_SELECT))
        else $error("cold reset kept clock");
    a_warm_keeps_clk: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        warm_src && !cold_src && !cold_r |=> $stable(current_clock_select_r))
        else $error("warm changed clock");
    a_flags_survive_warm: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        warm_src && !cold_src && !WRITE |=> (reset_cause_control_r & $past(reset_cause_control_r))
            == $past(reset_cause_control_r))
        else $error("warm reset lost a flag");

    // release sequence timing
    a_warm_quick: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        SOFT_RESET_INSN && !SYSTEM_RESET_OUT ##1 !any_src [*2] |-> !SYSTEM_RESET_OUT)
        else $error("warm release slow");
    a_ost_holds: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        state_r == RCS_OST |=> !CLOCK_READY)
        else $error("ready during start-up count");
    a_ready_fetch: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        $rose(CLOCK_READY) |-> FETCH_START && FETCH_ADDRESS == `RCS_RESET_VECTOR)
        else $error("no vector fetch at ready");
    a_monitor_after_ready: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        $rose(CLOCK_FAIL_MONITOR_ON) |-> CLOCK_READY && $past(CLOCK_READY, 8))
        else $error("monitor started early");
endmodule : rcs_sequencer

/* File: testbench/rcs_osc_model.sv */
// oscillator at the far side: one tick per oscillator period, free running
module rcs_osc_model #(
    parameter int DIV = 2
) (
    input wire logic clk,
    input wire logic rst_n,
    output logic tick
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt;
    // divider keeps the period slower than the system clock
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 0;
            tick <= 1'b0;
        end else begin
            cnt <= (cnt == DIV - 1) ? 0 : cnt + 1;
            tick <= (cnt == DIV - 1);
        end
    end
endmodule : rcs_osc_model

/* File: testbench/reset_cause_sequencer_tb_top.sv */
`include "rcs_cfg.svh"
module reset_cause_sequencer_tb_top
    import rcs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int SRC_BIT [6] = '{6, 4, 9, 15, 14, 7};
    logic clk = 1'b0, rst_n = 1'b0, por = 1'b0, bod = 1'b0, master_clear_pin_n = 1'b1, software_reset_flag = 1'b0;
    logic wdt = 1'b0, cfgm = 1'b0, trap = 1'b0, ill = 1'b0, wfuse = 1'b0, wr = 1'b0, rd = 1'b0;
    logic slp = 1'b0, idl = 1'b0;
    logic [2:0] init_sel = RCS_MODE_FRC, power_up_timer_sel = 3'h0, cur_sel;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000, rdata, cause_exp, rv;
    logic tick, rst_out, cold, ready, fetch, clock_fail_monitor_on, wdt_en, vreg;
    logic [23:0] fetch_addr;
    int fails = 0, samples_checked = 0, n;

    rcs_sequencer #(.TPWRT_CYC(64), .TLOCK_CYC(16), .TFSCM_CYC(16)) rcs_sequencer_inst (
        .CLOCK(clk), .RESET_N(rst_n), .POWER_ON_DET(por), .BROWN_OUT_DET(bod),
        .MASTER_CLEAR_PIN_N(master_clear_pin_n), .SOFT_RESET_INSN(software_reset_flag), .WATCHDOG_TIMEOUT(wdt),
        .CONFIG_MISMATCH(cfgm), .TRAP_CONFLICT(trap), .ILLEGAL_CONDITION(ill),
        .SLEEP_ENTERED(slp), .IDLE_ENTERED(idl), .WATCHDOG_FUSE_ENABLE(wfuse),
        .CLOCK_FAIL_ENABLE(1'b1), .INITIAL_CLOCK_SELECT(init_sel), .POWER_UP_TIMER_SELECT(power_up_timer_sel),
        .OSC_TICK(tick), .ADDR(addr), .WDATA(wdata), .WRITE(wr), .READ(rd), .RDATA(rdata),
        .SYSTEM_RESET_OUT(rst_out), .COLD_RESET(cold), .CURRENT_CLOCK_SELECT(cur_sel),
        .CLOCK_READY(ready), .FETCH_ADDRESS(fetch_addr), .FETCH_START(fetch),
        .CLOCK_FAIL_MONITOR_ON(clock_fail_monitor_on), .WATCHDOG_ENABLE(wdt_en), .REGULATOR_SLEEP_ACTIVE(vreg)
    );

    rcs_osc_model #(.DIV(2)) rcs_osc_model_inst (.clk(clk), .rst_n(rst_n), .tick(tick));

    // 50 ns system clock
    initial begin
        forever #25 clk = ~clk;
    end

    task automatic check(input logic [23:0] seen, input logic [23:0] exp, input string what);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t %s: saw %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : reg_wr

    // read data stand only in the cycle after the strobe
    task automatic reg_rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : reg_rd

    task automatic wait_ready(input int lim);
        n = 0;
        while (ready !== 1'b1 && n < lim) begin
            @(posedge clk);
            #1 n++;
        end
        if (n >= lim) check(1'b0, 1'b1, "ready timeout");
    endtask : wait_ready

    task automatic drive(input int s, input logic v);
        case (s)
            0: software_reset_flag <= v;
            1: wdt <= v;
            2: cfgm <= v;
            3: trap <= v;
            4: ill <= v;
            5: master_clear_pin_n <= !v;
            6: bod <= v;
            default: por <= v;
        endcase
    endtask : drive

    // holds one source for len cycles, reset output must follow it
    task automatic pulse(input int s, input int len);
        @(posedge clk);
        drive(s, 1'b1);
        for (int i = 0; i < len; i++) begin
            @(posedge clk);
            if (i == len - 1) drive(s, 1'b0);
            #1 check(rst_out, 1'b1, "reset out");
        end
    endtask : pulse

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : close_out

    // main sequence: boot, registers, brown-out, warm sources, power-on
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        wait_ready(700);
        check(n >= 600 && n <= 606, 1'b1, "por extension");
        check(cold, 1'b1, "cold");
        check(cur_sel, RCS_MODE_FRC, "clock sel");
        check(fetch, 1'b1, "fetch start");
        check(fetch_addr, 24'h000000, "fetch addr");
        check(clock_fail_monitor_on, 1'b0, "monitor early");
        repeat (20) @(posedge clk);
        #1 check(clock_fail_monitor_on, 1'b1, "monitor late");
        reg_rd(`RCS_ADDR_CAUSE, rv);
        check(rv, 16'h0003, "boot cause");
        reg_rd(`RCS_ADDR_STATUS, rv);
        check(rv, 16'h00e1, "boot status");
        $display("test boot done");
        reg_wr(`RCS_ADDR_CAUSE, 16'hffff);
        reg_rd(`RCS_ADDR_CAUSE, rv);
        check(rv, 16'hc3ff, "cause all set");
        check(rst_out, 1'b0, "no soft reset");
        check(wdt_en, 1'b1, "wdt soft on");
        check(vreg, 1'b1, "vreg on");
        reg_wr(`RCS_ADDR_CAUSE, 16'h0000);
        reg_rd(`RCS_ADDR_CAUSE, rv);
        check(rv, 16'h0000, "cause clear");
        check(wdt_en, 1'b0, "wdt off");
        check(vreg, 1'b0, "vreg off");
        @(posedge clk);
        wfuse <= 1'b1;
        @(posedge clk);
        #1 check(wdt_en, 1'b1, "wdt fuse");
        reg_rd(4'h5, rv);
        check(rv, 16'h0000, "unmapped read");
        $display("test registers done");
        reg_wr(`RCS_ADDR_CAUSE, 16'h0120);
        init_sel <= RCS_MODE_XTPLL;
        power_up_timer_sel <= 3'h7;
        pulse(6, 4);
        wait_ready(4400);
        check(n >= 4120 && n <= 4180, 1'b1, "bor release");
        check(cur_sel, RCS_MODE_XTPLL, "cold sel");
        check(cold, 1'b1, "cold bor");
        reg_rd(`RCS_ADDR_CAUSE, rv);
        check(rv, 16'h0122, "bor cause");
        $display("test brown-out done");
        init_sel <= RCS_MODE_FRC;
        reg_wr(`RCS_ADDR_CAUSE, 16'h0000);
        cause_exp = 16'h0000;
        for (int s = 0; s < 6; s++) begin
            pulse(s, (s == 0) ? 1 : 3);
            if (s == 0) begin
                @(posedge clk);
                #1 check(rst_out, 1'b0, "one cycle reset");
                check(fetch, 1'b1, "vector fetch");
            end
            wait_ready(10);
            cause_exp = cause_exp | (16'h0001 << SRC_BIT[s]);
            reg_rd(`RCS_ADDR_CAUSE, rv);
            check(rv, cause_exp, "warm cause");
            check(cold, 1'b0, "warm");
            check(cur_sel, RCS_MODE_XTPLL, "warm sel");
        end
        @(posedge clk);
        slp <= 1'b1;
        idl <= 1'b1;
        @(posedge clk);
        slp <= 1'b0;
        idl <= 1'b0;
        #1 check(rst_out, 1'b0, "sleep no reset");
        reg_rd(`RCS_ADDR_CAUSE, rv);
        check(rv, cause_exp | 16'h000c, "sleep idle flags");
        $display("test warm resets done");
        reg_wr(`RCS_ADDR_CAUSE, 16'h0140);
        power_up_timer_sel <= 3'h0;
        pulse(7, 2);
        wait_ready(700);
        reg_rd(`RCS_ADDR_CAUSE, rv);
        check(rv, 16'h0103, "por cause");
        check(cur_sel, RCS_MODE_FRC, "por sel");
        $display("test power-on done");
        close_out();
    end

    // cuts a hang short well beyond the expected run
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        close_out();
    end
endmodule : reset_cause_sequencer_tb_top
